// File: verilog/ids_top.sv
// Drive select and decode block between the host I/O bus and an embedded drive.
// Assumes host and drive pins are asynchronous; configuration and floppy status share the clock.
//
// Summary of operation
// - AT primary: low-byte enable for 1F0H-1F7H and 3F6H-3F7H when enabled.
// - AT secondary: low-byte enable for 170H-177H and 376H-377H instead.
// - XT mode: low-byte enable for 320H-323H accesses and for DMA.
// - High-byte enable only in AT mode with wide transfer indicated.
// - High-byte enable answers only the command block range selected.
// - High-byte enable never asserts in XT mode.
// - Command block select for 1F0H/170H ranges in AT, 320H-323H in XT.
// - Control block select for 3F6H-3F7H, or 376H-377H under AT secondary.
// - In XT mode the wide-transfer pin is the drive DMA acknowledge, low.
// - AT mode passes bit 7 for command block, 3F6H/376H, and writes of 3F7H/377H.
// - AT mode host read of 3F7H/377H returns the floppy disk-change status on bit 7.
// - XT mode leaves the drive bit 7 path unused.
// - Power invalid: inputs ignored, every output floats.
// - Power invalid holds the captured inputs, selects and bit 7 registers; the output enables clear.
`timescale 1ns/1ps
module ids_top (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    // Static configuration
    input  wire logic       xt_mode_i,
    input  wire logic       secondary_i,
    input  wire logic       drive_if_enable_i,
    // Host bus pins
    input  wire logic [9:0] host_addr_i,
    input  wire logic       host_ior_n_i,
    input  wire logic       host_iow_n_i,
    input  wire logic       host_aen_i,
    input  wire logic       host_data_bit7_i,
    output logic            host_data_bit7_o,
    output logic            host_data_bit7_oe_o,
    // Floppy status
    input  wire logic       disk_change_i,
    // Power
    input  wire logic       power_valid_i,
    // Drive pins
    input  wire logic       drive_wide_transfer_n_i,
    input  wire logic       drive_data_bit7_i,
    output logic            drive_data_bit7_o,
    output logic            drive_data_bit7_oe_o,
    output logic            drive_low_byte_enable_n_o,
    output logic            drive_high_byte_enable_n_o,
    output logic            drive_cmd_block_select_n_o,
    output logic            drive_ctrl_block_select_n_o,
    output logic            sel_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    localparam int unsigned PIN_W = ids_pkg::ADDR_W + 7;

    logic [PIN_W-1:0]  pins_async;
    logic [PIN_W-1:0]  pins_sync;
    ids_pkg::ids_host_t host_live;
    ids_pkg::ids_host_t host_held;
    ids_pkg::ids_cfg_t  cfg;
    ids_pkg::ids_sel_t  sel;
    logic              pwr_ok;
    logic              wide_n_live;
    logic              wide_n_held;
    logic              drive_d7_live;
    logic              drive_d7_held;

    assign pins_async = {host_addr_i, ~host_ior_n_i, ~host_iow_n_i, host_aen_i, host_data_bit7_i,
                         drive_wide_transfer_n_i, drive_data_bit7_i, power_valid_i};

    ids_sync #(
        .WIDTH (PIN_W)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .async_i   (pins_async),
        .sync_o    (pins_sync)
    );

    always_comb begin
        host_live.addr = pins_sync[PIN_W-1:7];
        host_live.rd   = pins_sync[6];
        host_live.wr   = pins_sync[5];
        host_live.aen  = pins_sync[4];
        host_live.d7   = pins_sync[3];
        wide_n_live    = pins_sync[2];
        drive_d7_live  = pins_sync[1];
        pwr_ok         = pins_sync[0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input capture, frozen while power is invalid

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            host_held     <= '0;
            wide_n_held   <= ids_pkg::SEL_IDLE;
            drive_d7_held <= ids_pkg::D7_IDLE;
        end else if (pwr_ok) begin
            host_held     <= host_live;
            wide_n_held   <= wide_n_live;
            drive_d7_held <= drive_d7_live;
        end
    end

    // Configuration is static and same-clock
    always_comb begin
        cfg.xt_mode   = xt_mode_i;
        cfg.secondary = secondary_i;
        cfg.enable    = drive_if_enable_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    ids_decode u_decode (
        .cfg_i    (cfg),
        .host_i   (host_held),
        .wide_n_i (wide_n_held),
        .sel_o    (sel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Select outputs, held while power is invalid

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            drive_low_byte_enable_n_o   <= ids_pkg::SEL_IDLE;
            drive_high_byte_enable_n_o  <= ids_pkg::SEL_IDLE;
            drive_cmd_block_select_n_o  <= ids_pkg::SEL_IDLE;
            drive_ctrl_block_select_n_o <= ids_pkg::SEL_IDLE;
        end else if (pwr_ok) begin
            drive_low_byte_enable_n_o   <= ~sel.lo_en;
            drive_high_byte_enable_n_o  <= ~sel.hi_en;
            drive_cmd_block_select_n_o  <= ~sel.cmd_sel;
            drive_ctrl_block_select_n_o <= ~sel.ctrl_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit 7 buffer between host and drive

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            host_data_bit7_o  <= ids_pkg::D7_IDLE;
            drive_data_bit7_o <= ids_pkg::D7_IDLE;
        end else if (pwr_ok) begin
            if (sel.d7_dskchg) begin
                host_data_bit7_o <= disk_change_i;
            end else if (sel.d7_to_host) begin
                host_data_bit7_o <= drive_d7_held;
            end
            if (sel.d7_to_drive) begin
                drive_data_bit7_o <= host_held.d7;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output enables, all released while power is invalid

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sel_oe_o             <= ids_pkg::OE_IDLE;
            host_data_bit7_oe_o  <= ids_pkg::OE_IDLE;
            drive_data_bit7_oe_o <= ids_pkg::OE_IDLE;
        end else begin
            sel_oe_o             <= pwr_ok;
            host_data_bit7_oe_o  <= pwr_ok && (sel.d7_to_host || sel.d7_dskchg);
            drive_data_bit7_oe_o <= pwr_ok && sel.d7_to_drive;
        end
    end

endmodule

// File: common/ids_pkg.sv
// Constants and carrier types for the drive select and decode block.
// Assumes a 10-bit host I/O address and a single 100 MHz system clock.
package ids_pkg;

    // Address widths and windows
    localparam int unsigned ADDR_W        = 10;
    localparam logic [9:0]  AT_PRI_CMD    = 10'h1f0;
    localparam logic [9:0]  AT_SEC_CMD    = 10'h170;
    localparam logic [9:0]  AT_CMD_SPAN   = 10'h008;
    localparam logic [9:0]  AT_PRI_CTRL   = 10'h3f6;
    localparam logic [9:0]  AT_SEC_CTRL   = 10'h376;
    localparam logic [9:0]  XT_CMD        = 10'h320;
    localparam logic [9:0]  XT_CMD_SPAN   = 10'h004;
    localparam logic [9:0]  XT_CTRL       = 10'h3f6;
    localparam logic [9:0]  CTRL_SPAN     = 10'h002;
    localparam logic [9:0]  CTRL_STAT_OFS = 10'h001;

    // Synchroniser depth
    localparam int unsigned SYNC_STAGES   = 2;

    // Reset values of the outputs
    localparam logic        SEL_IDLE      = 1'b1;
    localparam logic        OE_IDLE       = 1'b0;
    localparam logic        D7_IDLE       = 1'b0;

    // Static configuration from the configuration block
    typedef struct packed {
        logic xt_mode;
        logic secondary;
        logic enable;
    } ids_cfg_t;

    // Host bus cycle after synchronisation
    typedef struct packed {
        logic [9:0] addr;
        logic       rd;
        logic       wr;
        logic       aen;
        logic       d7;
    } ids_host_t;

    // Decoded selects, all active high inside the block
    typedef struct packed {
        logic lo_en;
        logic hi_en;
        logic cmd_sel;
        logic ctrl_sel;
        logic d7_to_drive;
        logic d7_to_host;
        logic d7_dskchg;
    } ids_sel_t;

endpackage

// File: verilog/ids_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes every bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
module ids_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    // Asynchronous input; both stages reset to zero
    input  wire logic [WIDTH-1:0] async_i,
    // Synchronised output
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule

// File: verilog/ids_decode.sv
// Combinational address decode for the drive selects and bit 7 path.
// Assumes synchronised host signals and static configuration.
`timescale 1ns/1ps
module ids_decode (
    // Configuration
    input  wire ids_pkg::ids_cfg_t  cfg_i,
    // Host cycle
    input  wire ids_pkg::ids_host_t host_i,
    // Drive status, active low
    input  wire logic               wide_n_i,
    // Decoded selects
    output ids_pkg::ids_sel_t       sel_o
);

    function automatic logic in_window(input logic [9:0] addr, input logic [9:0] base, input logic [9:0] span);
        in_window = (addr >= base) && (addr < 10'(base + span));
    endfunction

    logic [9:0] cmd_base;
    logic [9:0] ctrl_base;
    logic       io_cycle;
    logic       at_cmd;
    logic       at_ctrl;
    logic       at_stat;
    logic       xt_cmd;
    logic       xt_ctrl;
    logic       xt_dma;

    always_comb begin
        cmd_base  = cfg_i.secondary ? ids_pkg::AT_SEC_CMD : ids_pkg::AT_PRI_CMD;
        ctrl_base = cfg_i.secondary ? ids_pkg::AT_SEC_CTRL : ids_pkg::AT_PRI_CTRL;
        io_cycle  = cfg_i.enable && !host_i.aen && (host_i.rd || host_i.wr);
        at_cmd    = !cfg_i.xt_mode && io_cycle && in_window(host_i.addr, cmd_base, ids_pkg::AT_CMD_SPAN);
        at_ctrl   = !cfg_i.xt_mode && io_cycle && in_window(host_i.addr, ctrl_base, ids_pkg::CTRL_SPAN);
        at_stat   = at_ctrl && (host_i.addr == 10'(ctrl_base + ids_pkg::CTRL_STAT_OFS));
        xt_cmd    = cfg_i.xt_mode && io_cycle && in_window(host_i.addr, ids_pkg::XT_CMD, ids_pkg::XT_CMD_SPAN);
        xt_ctrl   = cfg_i.xt_mode && io_cycle && in_window(host_i.addr, ids_pkg::XT_CTRL, ids_pkg::CTRL_SPAN);
        // In XT mode the wide-transfer pin carries the DMA acknowledge
        xt_dma    = cfg_i.xt_mode && cfg_i.enable && !wide_n_i;

        sel_o.lo_en       = at_cmd || at_ctrl || xt_cmd || xt_dma;
        sel_o.hi_en       = at_cmd && !wide_n_i;
        sel_o.cmd_sel     = at_cmd || xt_cmd;
        sel_o.ctrl_sel    = at_ctrl || xt_ctrl;
        sel_o.d7_to_drive = at_cmd && host_i.wr || at_ctrl && host_i.wr;
        sel_o.d7_to_host  = (at_cmd || (at_ctrl && !at_stat)) && host_i.rd;
        sel_o.d7_dskchg   = at_stat && host_i.rd;
    end

endmodule

// File: bench/ids_props.sv
// Checker for the select, enable and bit 7 pins of ids_top.
// Assumes configuration only changes while reset is held.
`timescale 1ns/1ps
module ids_props (
    // Clock and reset
    input wire logic       sys_clk_i,
    input wire logic       reset_i,
    // Watched ports
    input wire logic       xt_mode_i,
    input wire logic       secondary_i,
    input wire logic [9:0] host_addr_i,
    input wire logic       power_valid_i,
    input wire logic       drive_wide_transfer_n_i,
    input wire logic       host_data_bit7_oe_o,
    input wire logic       drive_data_bit7_oe_o,
    input wire logic       drive_low_byte_enable_n_o,
    input wire logic       drive_high_byte_enable_n_o,
    input wire logic       drive_cmd_block_select_n_o,
    input wire logic       drive_ctrl_block_select_n_o,
    input wire logic       sel_oe_o
);
    logic [2:0] run_cnt;
    logic       ok;
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !power_valid_i) begin
            run_cnt <= 3'h0;
        end else if (run_cnt != 3'h7) begin
            run_cnt <= run_cnt + 3'h1;
        end
    end
    assign ok = (run_cnt == 3'h7);
    function automatic logic cmd_win(logic [9:0] a);
        if (xt_mode_i) return (a & 10'h3fc) == 10'h320;
        return (a & 10'h3f8) == (secondary_i ? 10'h170 : 10'h1f0);
    endfunction
    function automatic logic ctl_win(logic [9:0] a);
        return (a & 10'h3fe) == ((secondary_i && !xt_mode_i) ? 10'h376 : 10'h3f6);
    endfunction
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////
    a_hi_xt_off: assert property (xt_mode_i |-> drive_high_byte_enable_n_o)
        else $error("High enable active in XT mode");
    a_hi_wide_only: assert property (ok && !drive_high_byte_enable_n_o |->
        !xt_mode_i && !$past(drive_wide_transfer_n_i, 4)) else $error("High enable without wide");
    a_hi_in_cmd: assert property (ok && !drive_high_byte_enable_n_o |-> !drive_cmd_block_select_n_o)
        else $error("High enable outside command block");
    a_cmd_window: assert property (ok && !drive_cmd_block_select_n_o |->
        cmd_win($past(host_addr_i, 4))) else $error("Command select outside window");
    a_ctrl_window: assert property (ok && !drive_ctrl_block_select_n_o |->
        ctl_win($past(host_addr_i, 4))) else $error("Control select outside window");
    a_at_lo_sel: assert property (ok && !xt_mode_i && !(drive_cmd_block_select_n_o &&
        drive_ctrl_block_select_n_o) |-> !drive_low_byte_enable_n_o) else $error("Low enable missing");
    a_xt_lo_cmd: assert property (ok && xt_mode_i && !drive_cmd_block_select_n_o
        |-> !drive_low_byte_enable_n_o) else $error("XT low enable missing");
    a_xt_no_d7: assert property (ok && xt_mode_i |-> !drive_data_bit7_oe_o && !host_data_bit7_oe_o)
        else $error("Bit 7 driven in XT mode");
    a_pv_float: assert property (!power_valid_i [*4] |->
        !sel_oe_o && !drive_data_bit7_oe_o && !host_data_bit7_oe_o) else $error("Output not floated");
    a_pv_hold: assert property (!power_valid_i [*5] |-> $stable(drive_low_byte_enable_n_o) &&
        $stable(drive_cmd_block_select_n_o)) else $error("Select changed while power invalid");
    c_hi: cover property (!drive_high_byte_enable_n_o);
    c_ctrl: cover property (!drive_ctrl_block_select_n_o);
    c_float: cover property ($fell(sel_oe_o));
endmodule

// File: bench/ids_drive_model.sv
// Behavioural model of the embedded drive on the drive pins.
// Assumes the bench sets the wide request and the bit 7 value to return.
`timescale 1ns/1ps
module ids_drive_model (
    // Clock
    input  wire logic sys_clk_i,
    // Bench controls
    input  wire logic wide_req_i,
    input  wire logic data_i,
    // Drive pins
    input  wire logic bit7_oe_i,
    output logic      wide_n_o,
    output logic      bit7_o = 1'b0
);
    assign wide_n_o = !wide_req_i;
    // Line toggles while the block drives it; released, it returns data_i
    always @(posedge sys_clk_i) begin
        bit7_o <= bit7_oe_i ? !bit7_o : data_i;
    end
endmodule

// File: bench/testbench.sv
// Random and corner bench for ids_top.
// Assumes the drive model and checker in the same folder.
`timescale 1ns/1ps
module testbench;
    logic sys_clk_i = 1'b0, reset_i = 1'b1, xt_mode_i = 1'b0, secondary_i = 1'b0;
    logic drive_if_enable_i = 1'b1, host_ior_n_i = 1'b1, host_iow_n_i = 1'b1, host_aen_i = 1'b0;
    logic [9:0] host_addr_i = 10'h000;
    logic host_data_bit7_i = 1'b0, disk_change_i = 1'b0, power_valid_i = 1'b1, req16 = 1'b0, dd7 = 1'b0;
    wire logic host_data_bit7_o, host_data_bit7_oe_o, drive_wide_transfer_n_i, drive_data_bit7_i;
    wire logic drive_data_bit7_o, drive_data_bit7_oe_o, drive_low_byte_enable_n_o, sel_oe_o;
    wire logic drive_high_byte_enable_n_o, drive_cmd_block_select_n_o, drive_ctrl_block_select_n_o;
    int error_cnt = 0, check_count = 0, cyc = 0;
    logic [9:0] corners [12] = '{10'h1f0, 10'h1f7, 10'h1f8, 10'h3f6, 10'h3f7, 10'h3f5,
                                 10'h170, 10'h177, 10'h376, 10'h377, 10'h320, 10'h323};
    ids_top dut (.*);
    ids_drive_model u_drv (.sys_clk_i(sys_clk_i), .wide_req_i(req16), .data_i(dd7),
        .bit7_oe_i(drive_data_bit7_oe_o), .wide_n_o(drive_wide_transfer_n_i), .bit7_o(drive_data_bit7_i));
    ////////////////////////////////////////////////////////////////
    initial forever #5 sys_clk_i = !sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic step(int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic chk(logic [3:0] s, logic [3:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [3:0] exp_sel();
        logic st, cw, kw, xt;
        xt = xt_mode_i;
        st = drive_if_enable_i && !host_aen_i && !(host_ior_n_i && host_iow_n_i);
        cw = st && (xt ? (host_addr_i & 10'h3fc) == 10'h320
                       : (host_addr_i & 10'h3f8) == (secondary_i ? 10'h170 : 10'h1f0));
        kw = st && (host_addr_i & 10'h3fe) == ((secondary_i && !xt) ? 10'h376 : 10'h3f6);
        return {cw | (kw & !xt) | (xt & drive_if_enable_i & req16), !xt & cw & req16, cw, kw};
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [3:0] e;
        logic [2:0] sv;
        logic w, r;
        int k;
        k = $urandom(92);
        for (int c = 0; c < 4; c++) begin
            reset_i = 1'b1;
            {xt_mode_i, secondary_i, drive_if_enable_i} = {c == 2, c == 1, c != 3};
            step(12);
            reset_i = 1'b0;
            step(8);
            for (int t = 0; t < 16; t++) begin
                k = $urandom_range(15);
                host_addr_i = (k < 12) ? corners[k] : 10'($urandom);
                k = $urandom_range(2);
                host_ior_n_i = (k != 1);
                host_iow_n_i = (k != 2);
                host_aen_i = ($urandom_range(7) == 0);
                {req16, dd7, host_data_bit7_i, disk_change_i} = 4'($urandom);
                // Drive bit 7 needs the model's register plus the full input pipeline
                step(10);
                e = exp_sel();
                w = !xt_mode_i && !host_iow_n_i && |e[1:0];
                r = !xt_mode_i && !host_ior_n_i && |e[1:0];
                chk(drive_low_byte_enable_n_o, !e[3]);
                chk(drive_high_byte_enable_n_o, !e[2]);
                chk(drive_cmd_block_select_n_o, !e[1]);
                chk(drive_ctrl_block_select_n_o, !e[0]);
                chk({drive_data_bit7_oe_o, host_data_bit7_oe_o, sel_oe_o}, {w, r, 1'b1});
                if (w) chk(drive_data_bit7_o, host_data_bit7_i);
                if (r) chk(host_data_bit7_o, (e[0] && host_addr_i[0]) ? disk_change_i : dd7);
            end
            if (c == 0) begin
                {host_addr_i, host_ior_n_i, host_iow_n_i, host_aen_i, req16} = {10'h1f0, 4'h5};
                step(8);
                sv = {drive_low_byte_enable_n_o, drive_high_byte_enable_n_o, drive_cmd_block_select_n_o};
                power_valid_i = 1'b0;
                host_addr_i = 10'h3f6;
                step(8);
                chk({sel_oe_o, drive_data_bit7_oe_o, host_data_bit7_oe_o}, 3'h0);
                chk({drive_low_byte_enable_n_o, drive_high_byte_enable_n_o,
                     drive_cmd_block_select_n_o}, sv);
                chk(sv, 3'h0);
                power_valid_i = 1'b1;
                step(10);
            end
        end
        end_sim();
    end
endmodule
bind ids_top ids_props u_props (.*);
